// >>> common/snvm_pkg.sv
// Package: constants and types shared by both ends of the serial memory link
// ==========================================================================
package snvm_pkg;
   localparam int ADDR_W = 15;
   localparam int MEM_DEPTH = 32768;
   localparam int BYTE_W = 8;
   localparam int BITCNT_W = 4;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Arbitrary device-type code, not tied to any real part
   localparam logic [3:0] TYPE_CODE = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
   localparam int FIFO_DEPTH = 32;
   // Host divider tick: a quarter of one link clock period in system cycles
   // Faster than the legacy rate so that long transfers stay short to run
   localparam int CLK_HZ = 40000000;
   localparam int LINK_HZ = 500000;
   localparam int HALF_CYC = CLK_HZ / (4 * LINK_HZ);
   localparam int DIV_W = 10;
   typedef enum logic [1:0] {
      SNVM_CMD_WRITE,
      SNVM_CMD_READ,
      SNVM_CMD_SETADDR
   } snvm_cmd_t;
endpackage : snvm_pkg

// >>> common/snvm_link_if.sv
// Interface: two-wire link between host and memory device
interface snvm_link_if;
   logic sclOut;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // SDA open drain: low wins, pull-up otherwise; SCL is driven by the host alone
   assign scl = sclOut;
   assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
   modport host (output sclOut, output sdaHostOut, output sdaHostOe, input sda);
   modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
endinterface : snvm_link_if

// >>> hw/snvm_fifo.sv
// Module: parameterised valid/ready FIFO
module snvm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [PW:0] count_q, count_d;
   logic push, pop;
   assign inReady = (count_q != (PW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData = mem[rdPtr_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   always_comb begin
      wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
      count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
      end
   end
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end
endmodule : snvm_fifo

// >>> hw/snvm_device.sv
// Module: two-wire memory slave with auto-incrementing address latch
module snvm_device (
   input wire logic clock,
   input wire logic rst_b,
   snvm_link_if.dev link,
   input wire logic [2:0] chip_select_straps,
   input wire logic writeProtect,
   output logic busy,
   output logic [snvm_pkg::ADDR_W-1:0] curAddr
);
   import snvm_pkg::*;
   typedef enum logic [2:0] {
      IDLE, DEVADDR, ADDRHI, ADDRLO, WDATA, RDATA, RACK
   } snvm_dev_state_t;
   logic [BYTE_W-1:0] mem [MEM_DEPTH];
   // ==========================================================
   // Pin synchronisers
   logic [1:0] sclSync_q, sdaSync_q, wpSync_q;
   logic [2:0] csSync1_q, csSync2_q;
   logic sclPrev_q, sdaPrev_q;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sclSync_q <= 2'h3;
         sdaSync_q <= 2'h3;
         wpSync_q <= 2'h0;
         csSync1_q <= 3'h0;
         csSync2_q <= 3'h0;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclSync_q <= {sclSync_q[0], link.scl};
         sdaSync_q <= {sdaSync_q[0], link.sda};
         wpSync_q <= {wpSync_q[0], writeProtect};
         csSync1_q <= chip_select_straps;
         csSync2_q <= csSync1_q;
         sclPrev_q <= sclSync_q[1];
         sdaPrev_q <= sdaSync_q[1];
      end
   end
   logic scl, sda, sclRise, sclFall, startCond, stopCond;
   assign scl = sclSync_q[1];
   assign sda = sdaSync_q[1];
   assign sclRise = scl && !sclPrev_q;
   assign sclFall = !scl && sclPrev_q;
   assign startCond = scl && sclPrev_q && sdaPrev_q && !sda;
   assign stopCond = scl && sclPrev_q && !sdaPrev_q && sda;
   // ==========================================================
   // Protocol engine
   snvm_dev_state_t state_q, state_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic ackDrive_q, ackDrive_d, dataDrive_q, dataDrive_d, sdaOut_q, sdaOut_d;
   logic isRead_q, isRead_d;
   logic memWe;
   logic [BYTE_W-1:0] rdByte;
   logic [BYTE_W-1:0] rxByte;
   assign rdByte = mem[addr_q];
   assign rxByte = {shift_q[BYTE_W-2:0], sda};
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      addr_d = addr_q;
      ackDrive_d = ackDrive_q;
      dataDrive_d = dataDrive_q;
      sdaOut_d = sdaOut_q;
      isRead_d = isRead_q;
      memWe = 1'b0;
      if (startCond) begin
         state_d = DEVADDR;
         sdaOut_d = 1'b1;
         bitCnt_d = '0;
         ackDrive_d = 1'b0;
         dataDrive_d = 1'b0;
      end else if (stopCond) begin
         state_d = IDLE;
         sdaOut_d = 1'b1;
         ackDrive_d = 1'b0;
         dataDrive_d = 1'b0;
      end else if (state_q != IDLE && state_q != RDATA && state_q != RACK) begin
         if (sclRise && bitCnt_q <= BIT_LAST) begin
            shift_d = rxByte;
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == BIT_LAST) begin
               unique case (state_q)
                  DEVADDR: begin
                     ackDrive_d = (rxByte[7:4] == TYPE_CODE) && (rxByte[3:1] == csSync2_q);
                     isRead_d = rxByte[0];
                  end
                  ADDRHI: ackDrive_d = 1'b1;
                  ADDRLO: ackDrive_d = 1'b1;
                  WDATA: begin
                     ackDrive_d = !wpSync_q[1];
                     if (!wpSync_q[1]) begin
                        memWe = 1'b1;
                        addr_d = addr_q + ADDR_ONE;
                     end
                  end
                  default: ackDrive_d = 1'b0;
               endcase
               if (state_q == ADDRHI) begin
                  addr_d = {rxByte[ADDR_W-9:0], addr_q[7:0]};
               end else if (state_q == ADDRLO) begin
                  addr_d = {addr_q[ADDR_W-1:8], rxByte};
               end
            end
         end else if (sclFall && bitCnt_q == BIT_ACK) begin
            sdaOut_d = 1'b0;
         end else if (sclFall && bitCnt_q > BIT_ACK) begin
            // Park high, or ackPhase would pull SDA at the next eighth rise
            sdaOut_d = 1'b1;
            ackDrive_d = 1'b0;
            bitCnt_d = '0;
            if (!ackDrive_q) begin
               state_d = IDLE;
            end else if (state_q == DEVADDR && isRead_q) begin
               state_d = RDATA;
               dataDrive_d = 1'b1;
               shift_d = rdByte;
               sdaOut_d = rdByte[7];
               addr_d = addr_q + ADDR_ONE;
            end else begin
               unique case (state_q)
                  DEVADDR: state_d = ADDRHI;
                  ADDRHI: state_d = ADDRLO;
                  default: state_d = WDATA;
               endcase
            end
         end else if (sclRise && bitCnt_q == BIT_ACK) begin
            bitCnt_d = bitCnt_q + 4'h1;
         end
      end else if (state_q == RDATA) begin
         if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
         end else if (sclFall) begin
            if (bitCnt_q == BIT_ACK) begin
               dataDrive_d = 1'b0;
               state_d = RACK;
            end else begin
               shift_d = {shift_q[BYTE_W-2:0], 1'b0};
               sdaOut_d = shift_q[BYTE_W-2];
            end
         end
      end else if (state_q == RACK) begin
         if (sclRise) begin
            isRead_d = !sda; // master acknowledge
         end else if (sclFall) begin
            bitCnt_d = '0;
            if (isRead_q) begin
               state_d = RDATA;
               dataDrive_d = 1'b1;
               shift_d = rdByte;
               sdaOut_d = rdByte[7];
               addr_d = addr_q + ADDR_ONE;
            end else begin
               state_d = IDLE;
            end
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= IDLE;
         bitCnt_q <= '0;
         shift_q <= '0;
         addr_q <= ADDR_RESET;
         ackDrive_q <= 1'b0;
         dataDrive_q <= 1'b0;
         sdaOut_q <= 1'b1;
         isRead_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         addr_q <= addr_d;
         ackDrive_q <= ackDrive_d;
         dataDrive_q <= dataDrive_d;
         sdaOut_q <= sdaOut_d;
         isRead_q <= isRead_d;
      end
   end
   always_ff @(posedge clock) begin
      if (memWe) begin
         mem[addr_q] <= rxByte;
      end
   end
   // Ack only after the falling edge, held through the ninth clock
   logic ackPhase;
   assign ackPhase = ackDrive_q && bitCnt_q >= BIT_ACK && sdaOut_q == 1'b0
      && state_q != RDATA && state_q != RACK;
   assign link.sdaDevOut = ackPhase ? 1'b0 : sdaOut_q;
   assign link.sdaDevOe = ackPhase || dataDrive_q;
   assign busy = (state_q != IDLE);
   assign curAddr = addr_q;
endmodule : snvm_device

// >>> hw/snvm_host.sv
// Module: two-wire bus master with FIFO for write data
module snvm_host (
   input wire logic clock,
   input wire logic rst_b,
   snvm_link_if.host link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire snvm_pkg::snvm_cmd_t cmdKind,
   input wire logic [6:0] cmdDevSel,
   input wire logic [snvm_pkg::ADDR_W-1:0] cmdAddr,
   input wire logic [7:0] cmdLen,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [7:0] wrData,
   output logic rdValid,
   output logic [7:0] rdData,
   output logic nackSeen
);
   import snvm_pkg::*;
   typedef enum logic [2:0] {
      H_IDLE, H_START, H_BIT, H_STOP, H_DONE
   } snvm_host_state_t;
   logic tick;
   logic [DIV_W-1:0] div_q, div_d;
   assign tick = (div_q == DIV_W'(HALF_CYC - 1));
   always_comb div_d = tick ? '0 : div_q + 1'b1;
   logic fOutValid, fOutReady;
   logic [7:0] fOutData;
   snvm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) wrFifo (
      .clock(clock), .rst_b(rst_b),
      .inValid(wrValid), .inReady(wrReady), .inData(wrData),
      .outValid(fOutValid), .outReady(fOutReady), .outData(fOutData)
   );
   logic [1:0] sdaSync_q;
   snvm_host_state_t st_q, st_d;
   logic [1:0] phase_q, phase_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] byteIx_q, byteIx_d;
   logic [7:0] tx_q, tx_d, rx_q, rx_d, left_q, left_d;
   logic scl_q, scl_d, sda_q, sda_d, rdValid_q, rdValid_d, nack_q, nack_d;
   logic [7:0] rdData_q, rdData_d;
   snvm_cmd_t kind_q, kind_d;
   logic [6:0] sel_q, sel_d;
   logic [ADDR_W-1:0] adr_q, adr_d;
   logic txPhase, lastByte;
   assign txPhase = (kind_q == SNVM_CMD_READ) ? (byteIx_q == 3'h0) : 1'b1;
   // Read: the byte now arriving is the last one and gets the no-acknowledge
   assign lastByte = (kind_q == SNVM_CMD_READ) ? (left_q == 8'h01) : (left_q == 8'h00);
   // Pop together with the load into tx, from the first data byte on
   assign fOutReady = tick && st_q == H_BIT && phase_q == 2'h3 && bit_q == BIT_ACK
      && kind_q == SNVM_CMD_WRITE && byteIx_q >= 3'h2 && !lastByte && !sdaSync_q[1];
   always_comb begin
      st_d = st_q; phase_d = phase_q; bit_d = bit_q; byteIx_d = byteIx_q;
      tx_d = tx_q; rx_d = rx_q; left_d = left_q; scl_d = scl_q; sda_d = sda_q;
      rdValid_d = 1'b0; nack_d = nack_q; rdData_d = rdData_q;
      kind_d = kind_q; sel_d = sel_q; adr_d = adr_q;
      unique case (st_q)
         H_IDLE: if (cmdValid) begin
            kind_d = cmdKind; sel_d = cmdDevSel; adr_d = cmdAddr; left_d = cmdLen;
            st_d = H_START; phase_d = '0; nack_d = 1'b0; byteIx_d = '0;
         end
         H_START: if (tick) begin
            phase_d = phase_q + 2'h1;
            if (phase_q == 2'h0) begin sda_d = 1'b1; scl_d = 1'b1; end
            else if (phase_q == 2'h1) sda_d = 1'b0;
            else begin
               scl_d = 1'b0; st_d = H_BIT; phase_d = '0; bit_d = '0;
               tx_d = {sel_q, kind_q == SNVM_CMD_READ};
            end
         end
         H_BIT: if (tick) begin
            phase_d = phase_q + 2'h1;
            if (phase_q == 2'h0) begin
               sda_d = (bit_q == BIT_ACK) ? !(kind_q == SNVM_CMD_READ && byteIx_q != 3'h0
                  && !lastByte) : (txPhase ? tx_q[7] : 1'b1);
            end else if (phase_q == 2'h1) scl_d = 1'b1;
            else if (phase_q == 2'h2) begin
               if (bit_q == BIT_ACK) begin
                  if (txPhase && sdaSync_q[1]) nack_d = 1'b1;
               end else rx_d = {rx_q[6:0], sdaSync_q[1]};
            end else begin
               scl_d = 1'b0; phase_d = '0;
               if (bit_q != BIT_ACK) begin
                  bit_d = bit_q + 4'h1; tx_d = {tx_q[6:0], 1'b0};
               end else begin
                  // Saturates: only the first three bytes of a frame differ
                  bit_d = '0; byteIx_d = (byteIx_q == 3'h7) ? byteIx_q : byteIx_q + 3'h1;
                  if (!txPhase) begin
                     rdValid_d = 1'b1; rdData_d = rx_q; left_d = left_q - 8'h01;
                  end
                  if (nack_d && txPhase) st_d = H_STOP;
                  else if (kind_q == SNVM_CMD_READ) begin
                     if (byteIx_q != 3'h0 && lastByte) st_d = H_STOP;
                  end else if (byteIx_q == 3'h0) tx_d = {1'b0, adr_q[14:8]};
                  else if (byteIx_q == 3'h1) tx_d = adr_q[7:0];
                  else if (kind_q == SNVM_CMD_SETADDR) st_d = H_START;
                  else if (lastByte || !fOutValid) st_d = H_STOP;
                  else begin
                     tx_d = fOutData; left_d = left_q - 8'h01;
                  end
                  if (kind_q == SNVM_CMD_SETADDR && byteIx_q == 3'h2) begin
                     kind_d = SNVM_CMD_READ; byteIx_d = '0;
                  end
               end
            end
         end
         H_STOP: if (tick) begin
            phase_d = phase_q + 2'h1;
            if (phase_q == 2'h0) sda_d = 1'b0;
            else if (phase_q == 2'h1) scl_d = 1'b1;
            else begin sda_d = 1'b1; st_d = H_DONE; end
         end
         default: st_d = H_IDLE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sdaSync_q <= 2'h3; div_q <= '0; st_q <= H_IDLE; phase_q <= '0; bit_q <= '0;
         byteIx_q <= '0; tx_q <= '0; rx_q <= '0; left_q <= '0; scl_q <= 1'b1;
         sda_q <= 1'b1; rdValid_q <= 1'b0; nack_q <= 1'b0; rdData_q <= '0;
         kind_q <= SNVM_CMD_WRITE; sel_q <= '0; adr_q <= '0;
      end else begin
         sdaSync_q <= {sdaSync_q[0], link.sda}; div_q <= div_d; st_q <= st_d;
         phase_q <= phase_d; bit_q <= bit_d; byteIx_q <= byteIx_d; tx_q <= tx_d;
         rx_q <= rx_d; left_q <= left_d; scl_q <= scl_d; sda_q <= sda_d;
         rdValid_q <= rdValid_d; nack_q <= nack_d; rdData_q <= rdData_d;
         kind_q <= kind_d; sel_q <= sel_d; adr_q <= adr_d;
      end
   end
   assign cmdReady = (st_q == H_IDLE);
   assign link.sclOut = scl_q;
   assign link.sdaHostOut = 1'b0;
   assign link.sdaHostOe = !sda_q;
   assign rdValid = rdValid_q;
   assign rdData = rdData_q;
   assign nackSeen = nack_q;
endmodule : snvm_host

// >>> bench/snvm_link_sva.sv
// Checker: protocol assertions on the two-wire link between host and device
module snvm_link_sva (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic sdaHostOe,
   input wire logic sdaDevOe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Bit and byte position within the current frame
   logic sclP_q;
   logic sdaP_q;
   logic rwBit_q, rwBit_d;
   logic idle_q, idle_d;
   logic [3:0] bitIdx_q, bitIdx_d;
   logic [1:0] byteIdx_q, byteIdx_d;
   logic rise;
   logic start;
   logic stop;
   assign rise = scl && !sclP_q;
   assign start = scl && sclP_q && sdaP_q && !sda;
   assign stop = scl && sclP_q && !sdaP_q && sda;
   always_comb begin
      bitIdx_d = bitIdx_q;
      byteIdx_d = byteIdx_q;
      rwBit_d = rwBit_q;
      idle_d = idle_q;
      if (start) begin
         bitIdx_d = 4'h0;
         byteIdx_d = 2'h0;
         idle_d = 1'b0;
      end else if (stop) begin
         idle_d = 1'b1;
      end else if (rise) begin
         if (bitIdx_q == 4'h7 && byteIdx_q == 2'h0) begin
            rwBit_d = sda;
         end
         bitIdx_d = (bitIdx_q == 4'h8) ? 4'h0 : bitIdx_q + 4'h1;
         // Saturates: first byte versus later bytes, plus three bytes done for cov_restart
         if (bitIdx_q == 4'h8 && byteIdx_q != 2'h3) begin
            byteIdx_d = byteIdx_q + 2'h1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         rwBit_q <= 1'b0;
         idle_q <= 1'b1;
         bitIdx_q <= 4'h0;
         byteIdx_q <= 2'h0;
      end else begin
         sclP_q <= scl;
         sdaP_q <= sda;
         rwBit_q <= rwBit_d;
         idle_q <= idle_d;
         bitIdx_q <= bitIdx_d;
         byteIdx_q <= byteIdx_d;
      end
   end
   // ==========================================================
   // Assertions
   chk_host_release: assert property (
      rise && bitIdx_q == 4'h8 && (byteIdx_q == 2'h0 || !rwBit_q) |-> !sdaHostOe)
      else $error("host held SDA in the acknowledge slot");
   chk_dev_stable: assert property (
      scl && sclP_q |-> $stable(sdaDevOe))
      else $error("device changed SDA while SCL high");
   chk_dev_low_drive: assert property (
      $rose(sdaDevOe) |-> !scl [*8])
      else $error("device drove SDA outside the low phase");
   chk_ack_slot_only: assert property (
      $rose(sdaDevOe) && (byteIdx_q == 2'h0 || !rwBit_q) |-> bitIdx_q == 4'h8)
      else $error("device drove SDA while receiving");
   chk_read_release: assert property (
      rise && bitIdx_q == 4'h8 && rwBit_q && byteIdx_q != 2'h0 |-> !sdaDevOe)
      else $error("device held SDA in the master acknowledge slot");
   chk_read_drive: assert property (
      $rose(sdaDevOe) && rwBit_q && byteIdx_q != 2'h0 |-> bitIdx_q != 4'h8)
      else $error("device drove read data in the acknowledge slot");
   chk_idle_quiet: assert property (
      idle_q |-> !sdaDevOe)
      else $error("device drove SDA after a stop");
   chk_addr_listen: assert property (
      byteIdx_q == 2'h0 && bitIdx_q < 4'h8 |-> !sdaDevOe)
      else $error("device drove SDA during the slave address");
   cov_write_ack: cover property (rise && bitIdx_q == 4'h8 && !rwBit_q && byteIdx_q != 2'h0
      && !sda);
   cov_read_byte: cover property ($rose(sdaDevOe) && rwBit_q && byteIdx_q != 2'h0);
   cov_restart: cover property (start && byteIdx_q == 2'h3);
endmodule : snvm_link_sva

// >>> bench/testbench.sv
// Bench: host and memory device over the link
module testbench;
   import snvm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      snvm_cmd_t kind;
      logic [6:0] sel;
      logic [14:0] addr;
      logic [7:0] len;
      logic wp;
      logic nack;
      logic [14:0] endAddr;
   } snvm_row_t;
   // About 71k cycles of link traffic, with margin
   localparam int LIMIT = 90000;
   localparam logic [6:0] SEL = {TYPE_CODE, 3'h3};
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic wp = 1'b0;
   logic cmdValid = 1'b0;
   logic wrValid = 1'b0;
   snvm_cmd_t cmdKind = SNVM_CMD_READ;
   logic [6:0] cmdDevSel = 7'h00;
   logic [14:0] cmdAddr = 15'h0000;
   logic [7:0] cmdLen = 8'h01, wrData = 8'h00;
   logic cmdReady, wrReady, rdValid, nackSeen, busy;
   logic [7:0] rdData;
   logic [14:0] curAddr;
   logic [14:0] lat = 15'h0000;
   logic [7:0] mem [0:32767];
   logic [7:0] rq [$];
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   // Wrap at the top of memory, protect, wrong straps, wrong type
   snvm_row_t rows [7] = '{
      '{SNVM_CMD_WRITE, SEL, 15'h7ffe, 8'h04, 1'b0, 1'b0, 15'h0002},
      '{SNVM_CMD_SETADDR, SEL, 15'h7fff, 8'h02, 1'b0, 1'b0, 15'h0001},
      '{SNVM_CMD_READ, SEL, 15'h0000, 8'h01, 1'b0, 1'b0, 15'h0002},
      '{SNVM_CMD_WRITE, SEL, 15'h0000, 8'h01, 1'b1, 1'b1, 15'h0000},
      '{SNVM_CMD_READ, SEL, 15'h0000, 8'h01, 1'b0, 1'b0, 15'h0001},
      '{SNVM_CMD_READ, {TYPE_CODE, 3'h2}, 15'h0000, 8'h01, 1'b0, 1'b1, 15'h0001},
      '{SNVM_CMD_READ, {TYPE_CODE ^ 4'h8, 3'h3}, 15'h0000, 8'h01, 1'b0, 1'b1, 15'h0001}
   };
   always #12.5 clock = ~clock;
   snvm_link_if snvm_link_if_inst ();
   snvm_host snvm_host_inst (.clock(clock), .rst_b(rst_b), .link(snvm_link_if_inst),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdDevSel(cmdDevSel),
      .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady),
      .wrData(wrData), .rdValid(rdValid), .rdData(rdData), .nackSeen(nackSeen));
   snvm_device snvm_device_inst (.clock(clock), .rst_b(rst_b), .link(snvm_link_if_inst),
      .chip_select_straps(3'h3), .writeProtect(wp), .busy(busy), .curAddr(curAddr));
   snvm_link_sva snvm_link_sva_inst (.clock(clock), .rst_b(rst_b),
      .sdaHostOe(snvm_link_if_inst.sdaHostOe), .sdaDevOe(snvm_link_if_inst.sdaDevOe),
      .scl(snvm_link_if_inst.scl), .sda(snvm_link_if_inst.sda));
   // ==========================================================
   // Comparison and closing
   task automatic cmp_bit(input string what, input logic e, input logic s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask : cmp_bit
   task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask : cmp_byte
   task automatic cmp_addr(input string what, input logic [14:0] e, input logic [14:0] s);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask : cmp_addr
   task automatic give_verdict();
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         give_verdict();
      end
   end
   always @(posedge clock) begin
      if (rdValid === 1'b1) begin
         rq.push_back(rdData);
      end
   end
   // Offer 40 bytes to the host FIFO, past its refusal, mirroring accepted bytes at base
   task automatic fill_fifo(input logic [14:0] base, output int n);
      n = 0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clock);
         wrValid <= 1'b1;
         wrData <= 8'h5a ^ n[7:0];
         @(negedge clock);
         if (wrReady === 1'b1) begin
            mem[base + 15'(n)] = 8'h5a ^ n[7:0];
            n++;
         end
      end
      @(posedge clock);
      wrValid <= 1'b0;
   endtask : fill_fifo
   // ==========================================================
   // One command through the link, checked against the bench memory
   task automatic run_row(input snvm_row_t r, input bit load);
      logic [14:0] a;
      a = (r.kind == SNVM_CMD_READ) ? lat : r.addr;
      rq.delete();
      @(posedge clock);
      wp <= r.wp;
      for (int k = 0; k < r.len && r.kind == SNVM_CMD_WRITE && load; k++) begin
         wrValid <= 1'b1;
         wrData <= 8'h96 ^ k[7:0];
         if (!r.wp) begin
            mem[a + 15'(k)] = 8'h96 ^ k[7:0];
         end
         @(posedge clock);
      end
      wrValid <= 1'b0;
      cmdKind <= r.kind;
      cmdDevSel <= r.sel;
      cmdAddr <= r.addr;
      cmdLen <= r.len;
      cmdValid <= 1'b1;
      @(posedge clock);
      cmdValid <= 1'b0;
      repeat (4) @(posedge clock);
      do @(negedge clock); while (cmdReady !== 1'b1);
      // Device sees the stop a few cycles after the host has gone idle
      repeat (4) @(negedge clock);
      cmp_bit("nack", r.nack, nackSeen);
      cmp_bit("busy", 1'b0, busy);
      cmp_addr("latch", r.endAddr, curAddr);
      cmp_byte("count", (r.kind == SNVM_CMD_WRITE || r.nack) ? 8'h00 : r.len,
         8'(rq.size()));
      foreach (rq[k]) begin
         cmp_byte("read", mem[a + 15'(k)], rq[k]);
      end
      lat = r.endAddr;
   endtask : run_row
   initial begin
      int n;
      int m;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      cmp_bit("busy", 1'b0, busy);
      cmp_addr("latch", 15'h0000, curAddr);
      foreach (rows[i]) begin
         run_row(rows[i], 1'b1);
      end
      // ==========================================================
      // Host FIFO: fill until refused, drain by one long write, read back
      fill_fifo(15'h0100, n);
      @(negedge clock);
      cmp_byte("fifo fill", 8'(FIFO_DEPTH), n[7:0]);
      cmp_bit("fifo ready", 1'b0, wrReady);
      run_row('{SNVM_CMD_WRITE, SEL, 15'h0100, 8'h20, 1'b0, 1'b0, 15'h0120}, 1'b0);
      cmp_bit("fifo drain", 1'b1, wrReady);
      run_row('{SNVM_CMD_SETADDR, SEL, 15'h0100, 8'h20, 1'b0, 1'b0, 15'h0120}, 1'b1);
      // Every byte left the FIFO, so it takes a full load again
      fill_fifo(15'h0200, m);
      cmp_byte("fifo refill", 8'(FIFO_DEPTH), m[7:0]);
      // ==========================================================
      // Reset in the middle of a read
      @(posedge clock);
      cmdKind <= SNVM_CMD_READ;
      cmdDevSel <= SEL;
      cmdLen <= 8'h04;
      cmdValid <= 1'b1;
      @(posedge clock);
      cmdValid <= 1'b0;
      repeat (2000) @(posedge clock);
      cmp_bit("busy", 1'b1, busy);
      rst_b <= 1'b0;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      cmp_bit("busy", 1'b0, busy);
      cmp_bit("ready", 1'b1, cmdReady);
      cmp_bit("fifo ready", 1'b1, wrReady);
      cmp_addr("latch", 15'h0000, curAddr);
      give_verdict();
   end
endmodule : testbench
